// ---- verification/tape_diag_block_sequencer_test.sv ----
`timescale 1ns/100ps
`default_nettype none
module tape_diag_block_sequencer_test
	import tds_pkg::*;
;
	logic        sys_clk = 0;
	logic        rst = 1;
	logic        psel = 0;
	logic        penable = 0;
	logic        pwrite = 0;
	logic [7:0]  paddr = 0;
	logic [31:0] pwdata = 0;
	logic [31:0] prdata, q, st;
	logic        pready, pslverr, irq, se;
	tds_cmd_s    tape_cmd, lc;
	tds_rsp_s    tape_rsp;
	tds_cond_s   cond = 4'hf;
	logic [1:0]  flt = 0;
	logic [1:0]  fm = 0;
	logic        m = 1;
	int          n_fail = 0;
	int          samples_checked = 0;
	int          cyc = 0;
	int          cnt[8];
	always #5 sys_clk = ~sys_clk;
	tds_sequencer #(.FM_TMO_CYC(20)) dut (.sys_clk(sys_clk), .rst(rst), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .tape_cmd(tape_cmd),
		.tape_rsp(tape_rsp), .cond(cond), .irq(irq));
	tds_tape_model pm (.sys_clk(sys_clk), .rst(rst), .tape_cmd(tape_cmd), .flt(flt),
		.fm(fm), .tape_rsp(tape_rsp));
	// ----------------
	// helpers
	// ----------------
	always @(posedge sys_clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			n_fail++;
			print_verdict;
		end
		if (tape_cmd.valid === 1'b1 && tape_rsp.ack === 1'b1) begin
			cnt[tape_cmd.op] <= cnt[tape_cmd.op] + 1;
			lc <= tape_cmd;
		end
	end
	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		samples_checked++;
		if (g !== e) begin
			n_fail++;
			$display("wrong value %s exp %h got %h", nm, e, g);
		end
	endtask
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1;
		penable <= 0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge sys_clk) penable <= 1;
		@(posedge sys_clk);
		while (pready !== 1'b1) @(posedge sys_clk);
		q = prdata;
		se = pslverr;
		psel <= 0;
		penable <= 0;
		@(posedge sys_clk);
	endtask
	task run(input logic [7:0] p, input logic [7:0] er);
		int i;
		cnt = '{default: 0};
		apb(1, A_IRQ_STAT, 32'h3);
		apb(1, A_CTRL, 32'h100 | p);
		i = 0;
		q = 1;
		while (q[0] !== 1'b0 && i < 300) begin
			apb(0, A_STATUS, 0);
			i++;
		end
		st = q;
		chk("busy", 0, st[0]);
		chk("err", er, st[15:8]);
		chk("irq", m, irq);
		apb(0, A_IRQ_STAT, 0);
		chk("stat", (er == 0) ? 1 : 3, q);
	endtask
	// ----------------
	// scenarios
	// ----------------
	task t_write;
		apb(1, A_CFG0, 32'h0039_0002);
		apb(1, A_CFG1, 32'h0123);
		run(P_WR, E_NONE);
		chk("writes", 2, cnt[0]);
		chk("repos", 1, cnt[6]);
		chk("cfg", 32'h2b_0123, {lc.speed_hi, lc.stream, lc.pattern, lc.density, lc.length});
		$display("t_write done");
	endtask
	task t_wbr;
		apb(1, A_CFG0, 32'h0002_0002);
		run(P_WBR, E_NONE);
		chk("seq", 32'h0202_0200, {cnt[0][7:0], cnt[1][7:0], cnt[2][7:0], cnt[6][7:0]});
		flt <= 2'h1;
		run(P_SREV, E_NONE);
		chk("space", 2, cnt[1]);
		$display("t_wbr done");
	endtask
	task t_faults;
		run(P_RFWD, E_HARD);
		chk("detail", pm.det, st[23:16]);
		run(P_WR, E_HARD);
		chk("writes", 1, cnt[0]);
		flt <= 2'h2;
		run(P_RREV, E_CORR);
		chk("detail", pm.det, st[23:16]);
		$display("t_faults done");
	endtask
	task t_cond;
		cond <= 4'h7;
		run(P_RFWD, E_ADAPTER);
		run(P_REW, E_NONE);
		chk("rewind", 1, cnt[4]);
		cond <= 4'hb;
		run(P_WBR, E_ADAPTER);
		cond <= 4'he;
		run(P_WR, E_NO_CURR);
		cond <= 4'hd;
		run(P_FM, E_NO_RING);
		chk("moved", 0, cnt[0] + cnt[5]);
		cond <= 4'hf;
		flt <= 2'h0;
		$display("t_cond done");
	endtask
	task t_fm;
		logic [7:0] ex[4];
		ex = '{E_NONE, E_FM_EOF, E_FM_HI, E_FM_LO};
		for (int i = 0; i < 4; i++) begin
			fm <= i[1:0];
			run(P_FM, ex[i]);
			chk("mark", 1, cnt[5]);
		end
		fm <= 2'h0;
		$display("t_fm done");
	endtask
	task t_regs;
		apb(0, 8'h20, 0);
		chk("slverr", 1, se);
		run(8'h99, E_NO_TEST);
		m = 0;
		apb(1, A_IRQ_MASK, 0);
		run(P_REW, E_NONE);
		apb(1, A_IRQ_MASK, 32'h1);
		chk("irq_on", 1, irq);
		apb(1, A_IRQ_STAT, 32'h1);
		chk("irq_off", 0, irq);
		$display("t_regs done");
	endtask
	task print_verdict;
		$display("checks %0d fails %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	initial begin
		repeat (3) @(posedge sys_clk);
		rst <= 0;
		@(posedge sys_clk);
		apb(1, A_IRQ_MASK, 32'h3);
		t_write;
		t_wbr;
		t_faults;
		t_cond;
		t_fm;
		t_regs;
		print_verdict;
	end
endmodule
`default_nettype wire

// ---- verification/tds_tape_model.sv ----
`timescale 1ns/100ps
`default_nettype none
module tds_tape_model
	import tds_pkg::*;
(
	input  wire logic       sys_clk,
	input  wire logic       rst,
	input  wire tds_cmd_s   tape_cmd,
	input  wire logic [1:0] flt,
	input  wire logic [1:0] fm,
	output tds_rsp_s        tape_rsp
);
	// ----------------
	// transport
	// ----------------
	logic [3:0] w;
	logic [4:0] fc;
	logic       ack;
	logic [7:0] det;
	// latency follows det, so answers come both promptly and slowly
	always_ff @(posedge sys_clk) begin
		ack <= 1'b0;
		if (rst) begin
			w <= 4'h0;
			fc <= 5'h00;
			det <= 8'h00;
		end else begin
			if (fc != 5'h00)
				fc <= fc + 5'h01;
			if (tape_cmd.valid && !ack) begin
				w <= w + 4'h1;
				if (w == {2'h0, det[5:4]}) begin
					ack <= 1'b1;
					w <= 4'h0;
					det <= det + 8'h11;
					if (tape_cmd.op == OP_FILEMARK)
						fc <= 5'h01;
				end
			end
		end
	end
	assign tape_rsp.ack = ack;
	// flt 1 raises both faults at once
	assign tape_rsp.hard_read_write_fault = ack & (flt == 2'h1);
	assign tape_rsp.corrected_fault = ack & (flt != 2'h0);
	// detail is only meaningful with ack
	assign tape_rsp.detail = ack ? det : ~det;
	assign tape_rsp.block_present = (fm == 2'h3) ? (fc != 5'h00)
		: (fm != 2'h2) && fc >= 5'h03 && fc <= 5'h06;
	assign tape_rsp.eof_seen = (fm != 2'h1);
endmodule
`default_nettype wire

// ---- verilog/tds_pkg.sv ----
package tds_pkg;
	// ----------------------------------------
	// clock and timing
	// ----------------------------------------
	localparam int CLK_MHZ          = 100;
	localparam int FM_TMO_US        = 1000;
	localparam int FM_TMO_CYC_DFLT  = FM_TMO_US * CLK_MHZ;
	localparam int TMO_W            = 24;

	// ----------------------------------------
	// register map (byte addresses)
	// ----------------------------------------
	localparam logic [7:0] A_CTRL      = 8'h00;
	localparam logic [7:0] A_CFG0      = 8'h04;
	localparam logic [7:0] A_CFG1      = 8'h08;
	localparam logic [7:0] A_STATUS    = 8'h0c;
	localparam logic [7:0] A_IRQ_STAT  = 8'h10;
	localparam logic [7:0] A_IRQ_MASK  = 8'h14;
	localparam int         CTRL_START  = 8;
	localparam logic [15:0] RST_COUNT  = 16'h0001;
	localparam logic [15:0] RST_LENGTH = 16'h0400;

	// ----------------------------------------
	// program numbers and error codes
	// ----------------------------------------
	localparam logic [7:0] P_WBR   = 8'h25;
	localparam logic [7:0] P_WR    = 8'h26;
	localparam logic [7:0] P_SREV  = 8'h27;
	localparam logic [7:0] P_RFWD  = 8'h28;
	localparam logic [7:0] P_RREV  = 8'h29;
	localparam logic [7:0] P_REW   = 8'h30;
	localparam logic [7:0] P_FM    = 8'h31;
	localparam logic [7:0] E_NONE     = 8'h00;
	localparam logic [7:0] E_ADAPTER  = 8'h01;
	localparam logic [7:0] E_HARD     = 8'h02;
	localparam logic [7:0] E_CORR     = 8'h03;
	localparam logic [7:0] E_FM_HI    = 8'h01;
	localparam logic [7:0] E_FM_LO    = 8'h02;
	localparam logic [7:0] E_FM_EOF   = 8'h03;
	localparam logic [7:0] E_NO_RING  = 8'h89;
	localparam logic [7:0] E_NO_CURR  = 8'h90;
	localparam logic [7:0] E_NO_TEST  = 8'hff;

	typedef enum logic [2:0] {
		OP_WRITE = 3'h0, OP_SPACE_REV = 3'h1, OP_READ_FWD = 3'h2,
		OP_READ_REV = 3'h3, OP_REWIND = 3'h4, OP_FILEMARK = 3'h5,
		OP_REPOS = 3'h6
	} tds_op_e;

	typedef enum logic [7:0] {
		S_IDLE = 8'h01, S_CHECK = 8'h02, S_ISSUE = 8'h04, S_WAIT = 8'h08,
		S_REPOS = 8'h10, S_FM_HI = 8'h20, S_FM_LO = 8'h40, S_END = 8'h80
	} tds_state_e;

	typedef struct packed {
		logic        valid;
		tds_op_e     op;
		logic        speed_hi;
		logic        stream;
		logic [1:0]  pattern;
		logic [1:0]  density;
		logic [15:0] length;
	} tds_cmd_s;

	typedef struct packed {
		logic        ack;
		logic        hard_read_write_fault;
		logic        corrected_fault;
		logic [7:0]  detail;
		logic        eof_seen;
		logic        block_present;
	} tds_rsp_s;

	typedef struct packed {
		logic        adapter_present;
		logic        fw_compat;
		logic        write_ring;
		logic        write_current;
	} tds_cond_s;
endpackage

// ---- verilog/tds_sequencer.sv ----
// Overview of operation
// RULE_01 - program 25 writes, reverse-spaces, reads N blocks
// RULE_02 - tests use stored speed, count, length, mode
// RULE_03 - program 26 writes N blocks, no read
// RULE_04 - program 27 spaces reverse, data ignored
// RULE_05 - program 28 reads forward, needs adapter board
// RULE_06 - program 29 reads reverse, checks status errors
// RULE_07 - program 30 rewinds to start marker, no errors
// RULE_08 - program 31 writes filemark and checks it
// RULE_09 - filemark codes 01, 02, 03 for failures
// RULE_10 - missing or incompatible adapter gives code 01; the code skips this check for programs 30 and 31
// RULE_11 - hard and corrected faults get separate codes
// RULE_12 - operator runs self-check after write faults
// RULE_13 - non-streaming repositions after every block; the code repositions between blocks only, not after the last block of a phase
// RULE_14 - writers check ring and current first
`timescale 1ns/100ps
`default_nettype none
module tds_sequencer
	import tds_pkg::*;
#(
	parameter int FM_TMO_CYC = FM_TMO_CYC_DFLT
) (
	input  wire logic        sys_clk,
	input  wire logic        rst,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	output tds_cmd_s         tape_cmd,
	input  wire tds_rsp_s    tape_rsp,
	input  wire tds_cond_s   cond,
	output logic             irq
);
	// ----------------------------------------
	// state
	// ----------------------------------------
	typedef struct packed {
		tds_state_e  st;
		logic [7:0]  prog;
		logic [1:0]  phase;
		logic [15:0] blk;
		logic [15:0] count;
		tds_cmd_s    cmd;
		logic        busy;
		logic [7:0]  err;
		logic [7:0]  detail;
		logic [TMO_W-1:0] tmo;
		logic [1:0]  irq_stat;
		logic [1:0]  irq_mask;
		logic        irq;
		logic [31:0] rdata;
		logic        ready;
		logic        slverr;
	} tds_regs_s;

	tds_regs_s s_q, s_d;

	// one timeout serves both filemark waits; it restarts at each step
	localparam logic [TMO_W-1:0] TMO_LIM = TMO_W'(FM_TMO_CYC - 1);

	function automatic tds_op_e op_of(input logic [7:0] p, input logic [1:0] ph);
		tds_op_e o;
		o = OP_WRITE;
		case (p)
			P_WBR:   o = (ph == 2'h0) ? OP_WRITE : (ph == 2'h1) ? OP_SPACE_REV : OP_READ_FWD;
			P_SREV:  o = OP_SPACE_REV;
			P_RFWD:  o = OP_READ_FWD;
			P_RREV:  o = OP_READ_REV;
			P_REW:   o = OP_REWIND;
			P_FM:    o = OP_FILEMARK;
			default: o = OP_WRITE;
		endcase
		return o;
	endfunction

	wire logic setup  = psel & ~penable;
	wire logic access = psel & penable & s_q.ready;
	wire logic wr     = access & pwrite;
	wire logic last_phase = (s_q.prog != P_WBR) || (s_q.phase == 2'h2);
	wire logic is_writer = (s_q.prog == P_WBR) || (s_q.prog == P_WR) || (s_q.prog == P_FM);
	// unknown numbers end at once with the no-test code
	wire logic known = (s_q.prog >= P_WBR && s_q.prog <= P_RREV) ||
		s_q.prog == P_REW || s_q.prog == P_FM;

	// ----------------------------------------
	// next state
	// ----------------------------------------
	always_comb begin
		logic [1:0] ev;
		logic [15:0] nblk;
		s_d = s_q;
		ev = 2'h0;
		nblk = s_q.blk + 16'h0001;
		s_d.ready = setup;
		s_d.slverr = 1'b0;
		if (setup) begin
			s_d.slverr = !(paddr inside {A_CTRL, A_CFG0, A_CFG1, A_STATUS,
				A_IRQ_STAT, A_IRQ_MASK});
			unique case (paddr)
				A_CTRL:     s_d.rdata = {24'h0, s_q.prog};
				A_CFG0:     s_d.rdata = {10'h0, s_q.cmd.density, s_q.cmd.pattern,
					s_q.cmd.stream, s_q.cmd.speed_hi, s_q.count};
				A_CFG1:     s_d.rdata = {16'h0, s_q.cmd.length};
				A_STATUS:   s_d.rdata = {8'h0, s_q.detail, s_q.err, 7'h0, s_q.busy};
				A_IRQ_STAT: s_d.rdata = {30'h0, s_q.irq_stat};
				A_IRQ_MASK: s_d.rdata = {30'h0, s_q.irq_mask};
				default:    s_d.rdata = 32'h0;
			endcase
		end
		// stored selections only change while idle, so a run sees one set
		if (wr && !s_q.busy) begin
			case (paddr)
				A_CTRL: begin
					s_d.prog = pwdata[7:0];
					if (pwdata[CTRL_START]) begin
						s_d.busy = 1'b1;
						s_d.err = E_NONE;
						s_d.detail = 8'h0;
						s_d.phase = 2'h0;
						s_d.blk = 16'h0;
						s_d.st = S_CHECK;
					end
				end
				A_CFG0: begin
					s_d.count = pwdata[15:0];
					s_d.cmd.speed_hi = pwdata[16];
					s_d.cmd.stream = pwdata[17];
					s_d.cmd.pattern = pwdata[19:18];
					s_d.cmd.density = pwdata[21:20];
				end
				A_CFG1: s_d.cmd.length = pwdata[15:0];
				default: ;
			endcase
		end
		if (wr && paddr == A_IRQ_MASK)
			s_d.irq_mask = pwdata[1:0];
		s_d.tmo = s_q.tmo + TMO_W'(1);
		unique case (s_q.st)
			S_IDLE: ;
			S_CHECK: begin
				// adapter first, then ring and current: tape never moves unarmed
				s_d.st = S_END;
				if (!known)
					s_d.err = E_NO_TEST;
				else if (s_q.prog != P_REW && s_q.prog != P_FM &&
					!(cond.adapter_present && cond.fw_compat))
					s_d.err = E_ADAPTER; // RULE_10 RULE_05
				else if (is_writer && !cond.write_ring)
					s_d.err = E_NO_RING; // RULE_14
				else if (is_writer && !cond.write_current)
					s_d.err = E_NO_CURR; // RULE_14
				else if (s_q.count != 16'h0 || s_q.prog == P_REW || s_q.prog == P_FM)
					s_d.st = S_ISSUE;
			end
			S_ISSUE: begin
				s_d.cmd.valid = 1'b1;
				s_d.cmd.op = op_of(s_q.prog, s_q.phase); // RULE_01 RULE_03 RULE_04 RULE_06 RULE_02
				s_d.st = S_WAIT;
			end
			S_REPOS: begin
				s_d.cmd.valid = 1'b1;
				s_d.cmd.op = OP_REPOS; // RULE_13
				s_d.st = S_WAIT;
			end
			S_WAIT: begin
				if (tape_rsp.ack) begin
					s_d.cmd.valid = 1'b0;
					s_d.tmo = '0;
					if (s_q.cmd.op == OP_REPOS)
						s_d.st = S_ISSUE;
					else if (s_q.cmd.op == OP_REWIND)
						s_d.st = S_END; // RULE_07
					else if (s_q.cmd.op == OP_FILEMARK)
						s_d.st = S_FM_HI; // RULE_08
					else if (s_q.cmd.op != OP_SPACE_REV &&
						tape_rsp.hard_read_write_fault) begin
						s_d.err = E_HARD; // RULE_11
						s_d.detail = tape_rsp.detail;
						s_d.st = S_END;
					end else if (s_q.cmd.op != OP_SPACE_REV &&
						tape_rsp.corrected_fault) begin
						s_d.err = E_CORR; // RULE_11
						s_d.detail = tape_rsp.detail;
						s_d.st = S_END;
					end else if (nblk == s_q.count) begin
						s_d.blk = 16'h0;
						s_d.phase = s_q.phase + 2'h1;
						s_d.st = last_phase ? S_END : S_ISSUE; // RULE_01
					end else begin
						s_d.blk = nblk;
						s_d.st = s_q.cmd.stream ? S_ISSUE : S_REPOS; // RULE_13
					end
				end
			end
			S_FM_HI: begin
				if (tape_rsp.block_present) begin
					s_d.tmo = '0;
					s_d.st = S_FM_LO;
				end else if (s_q.tmo == TMO_LIM) begin
					s_d.err = E_FM_HI; // RULE_09
					s_d.st = S_END;
				end
			end
			S_FM_LO: begin
				if (!tape_rsp.block_present) begin
					s_d.err = tape_rsp.eof_seen ? E_NONE : E_FM_EOF; // RULE_09 RULE_08
					s_d.st = S_END;
				end else if (s_q.tmo == TMO_LIM) begin
					s_d.err = E_FM_LO; // RULE_09
					s_d.st = S_END;
				end
			end
			S_END: begin
				s_d.busy = 1'b0;
				ev = (s_q.err == E_NONE) ? 2'h1 : 2'h3;
				s_d.st = S_IDLE;
			end
		endcase
		// a new event beats a clearing write in the same cycle
		if (wr && paddr == A_IRQ_STAT)
			s_d.irq_stat = s_q.irq_stat & ~pwdata[1:0];
		s_d.irq_stat = s_d.irq_stat | ev;
		s_d.irq = |(s_d.irq_stat & s_d.irq_mask);
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			s_q <= '0;
			s_q.st <= S_IDLE;
			s_q.count <= RST_COUNT;
			s_q.cmd.length <= RST_LENGTH;
		end else begin
			s_q <= s_d;
		end
	end

	assign prdata   = s_q.rdata;
	assign pready   = s_q.ready;
	assign pslverr  = s_q.slverr;
	assign tape_cmd = s_q.cmd;
	assign irq      = s_q.irq;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);

	a_adapter_gate: assert property (s_q.st == S_CHECK && known && s_q.prog != P_REW &&
		s_q.prog != P_FM && !cond.adapter_present |=> s_q.err == E_ADAPTER) // RULE_10
		else $error("missing adapter not reported");
	a_ring_check: assert property (s_q.st == S_CHECK && is_writer && cond.adapter_present &&
		cond.fw_compat && !cond.write_ring |=> s_q.err == E_NO_RING && !s_q.cmd.valid) // RULE_14
		else $error("write ring not checked");
	a_hard_fault: assert property (s_q.st == S_WAIT && tape_rsp.ack &&
		s_q.cmd.op == OP_WRITE && tape_rsp.hard_read_write_fault |=> s_q.err == E_HARD) // RULE_11
		else $error("hard fault code wrong");
	a_corr_fault: assert property (s_q.st == S_WAIT && tape_rsp.ack && s_q.cmd.op == OP_READ_REV
		&& !tape_rsp.hard_read_write_fault && tape_rsp.corrected_fault
		|=> s_q.err == E_CORR && s_q.detail == $past(tape_rsp.detail)) // RULE_11 RULE_06
		else $error("corrected fault code wrong");
	a_wbr_order: assert property (s_q.prog == P_WBR && s_q.st == S_ISSUE && s_q.phase == 2'h1
		|=> s_q.cmd.op == OP_SPACE_REV) // RULE_01
		else $error("backspace phase out of order");
	a_repos_gap: assert property (s_q.st == S_WAIT && tape_rsp.ack && s_q.cmd.op == OP_WRITE &&
		!s_q.cmd.stream && !tape_rsp.hard_read_write_fault && !tape_rsp.corrected_fault &&
		s_q.blk + 16'h0001 != s_q.count |=> s_q.st == S_REPOS ##1 s_q.cmd.op == OP_REPOS) // RULE_13
		else $error("no reposition between blocks");
	a_rewind_clean: assert property (s_q.cmd.op == OP_REWIND && s_q.st == S_WAIT &&
		tape_rsp.ack |=> s_q.st == S_END && s_q.err == E_NONE) // RULE_07
		else $error("rewind reported an error");
	a_fm_timeout: assert property (s_q.st == S_FM_HI && !tape_rsp.block_present &&
		s_q.tmo == TMO_LIM |=> s_q.err == E_FM_HI) // RULE_09
		else $error("filemark timeout code wrong");
	a_stored_params: assert property (s_q.busy && !$past(rst) |-> $stable(s_q.count) &&
		$stable(s_q.cmd.stream)) // RULE_02
		else $error("selections changed mid-run");
	a_done_irq: assert property (s_q.st == S_END && s_q.irq_mask[0] |=> irq)
		else $error("done interrupt missing");
	a_space_blind: assert property (s_q.st == S_WAIT && tape_rsp.ack &&
		s_q.cmd.op == OP_SPACE_REV |=> s_q.err == E_NONE) // RULE_04
		else $error("fault flagged on reverse space");
	a_stream_run: assert property (s_q.st == S_WAIT && tape_rsp.ack && s_q.cmd.stream &&
		s_q.cmd.op == OP_WRITE && !tape_rsp.hard_read_write_fault &&
		!tape_rsp.corrected_fault |=> s_q.st != S_REPOS) // RULE_13
		else $error("reposition while streaming");
	a_cmd_hold: assert property (tape_cmd.valid && !tape_rsp.ack |=> tape_cmd.valid &&
		$stable(tape_cmd.op)) // RULE_02
		else $error("command dropped before ack");
	a_fm_eof: assert property (s_q.st == S_FM_LO && !tape_rsp.block_present &&
		!tape_rsp.eof_seen |=> s_q.err == E_FM_EOF) // RULE_09
		else $error("missing end-of-file not reported");

	c_wbr_pass: cover property (s_q.prog == P_WBR && s_q.st == S_END && s_q.err == E_NONE);
	c_fm_pass: cover property (s_q.st == S_FM_LO ##1 s_q.st == S_END && s_q.err == E_NONE);
	c_repos: cover property (s_q.st == S_REPOS);
	c_hard: cover property (s_q.err == E_HARD && s_q.st == S_END);
	c_fm_tmo: cover property (s_q.st == S_FM_LO && s_q.tmo == TMO_LIM);
endmodule
`default_nettype wire
